// [hdl/loop_gain_config.sv]
// Loop filter damping and phase detector 2 gain configuration registers
// Notes on behaviour
// [R1] Damping codes 1, 2, 3 give factors 1.2, 2.5, 5 at every bandwidth.
// [R2] Code 4 gives 5 at 18 Hz else 10; code 5 gives 5, 10, 20 at 18, 35, 70 Hz.
// [R3] Damping register bits 6:4 are the first loop gain for analog lock at 8 kHz or less.
// [R4] That low frequency gain is applied only while the first loop auto gain select is on; second loop analog low lock uses it whatever that select is.
// [R5] With gain enable bit 7 clear the second loop does not use phase detector 2.
// [R6] With it set the gain follows lock mode: digital, high analog, or low analog field.
// [R7] Gain register bits 6:4 are the second loop gain for analog lock above 8 kHz.
// [R8] The high frequency analog field is ignored while auto gain select is off.
// [R9] Bits 2:0 are the digital feedback gain and are always applied when auto select is off.
// [R10] Unused bits 7 and 3 of the damping register and bit 3 of the gain register read zero.
`timescale 1ns/1ps
`default_nettype none
module loop_gain_config
	import loop_gain_pkg::*;
(
	input  wire logic            i_clock,
	input  wire logic            i_reset_n,
	input  wire reg_request_type i_request,
	input  wire bandwidth_type   i_loop1_bandwidth,
	input  wire lock_mode_type   i_loop1_lock_mode,
	input  wire logic            i_loop1_auto_gain_select,
	input  wire lock_mode_type   i_loop2_lock_mode,
	output logic [7:0]           o_read_data,
	output logic [7:0]           o_loop1_damping_factor,
	output logic [2:0]           o_loop1_lowfreq_gain,
	output logic                 o_loop1_lowfreq_gain_valid,
	output logic                 o_loop2_detector_enable,
	output logic [2:0]           o_loop2_detector_gain
);

	// Reset release synchroniser; assertion stays asynchronous
	// Release is held back two edges so no flop leaves reset on a marginal edge
	logic reset_meta_n;
	logic reset_sync_n;
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			reset_meta_n <= 1'b0;
			reset_sync_n <= 1'b0;
		end else begin
			reset_meta_n <= 1'b1;
			reset_sync_n <= reset_meta_n;
		end
	end

	// Register storage
	// Held as the packed layouts so the field names follow the bit positions
	damping_reg_type loop1_damping_config;
	gain_reg_type    loop2_detector_gain_config;

	// Address decode
	// A strobe qualifies the decode; an address alone changes nothing
	wire hit_damping = (i_request.address == LOOP1_DAMPING_OFFSET);
	wire hit_gain    = (i_request.address == LOOP2_GAIN_OFFSET);
	wire write_damping = i_request.write_strobe && hit_damping;
	wire write_gain    = i_request.write_strobe && hit_gain;

	// Unused bits masked off so they never store a one
	wire [7:0] next_damping = i_request.write_data & LOOP1_DAMPING_MASK; // R10
	wire [7:0] next_gain    = i_request.write_data & LOOP2_GAIN_MASK; // R10

	// Configuration register writes
	// The two hits exclude each other, so no write priority is needed
	always_ff @(posedge i_clock or negedge reset_sync_n) begin
		if (!reset_sync_n) begin
			loop1_damping_config       <= damping_reg_type'(LOOP1_DAMPING_RESET);
			loop2_detector_gain_config <= gain_reg_type'(LOOP2_GAIN_RESET);
		end else begin
			if (write_damping) begin
				loop1_damping_config <= damping_reg_type'(next_damping);
			end
			if (write_gain) begin
				loop2_detector_gain_config <= gain_reg_type'(next_gain);
			end
		end
	end

	// Read mux; unmapped addresses read zero
	// Reading has no side effect, so a repeated read returns the same value
	wire [7:0] next_read_data = hit_damping ? 8'(loop1_damping_config) :
		hit_gain ? 8'(loop2_detector_gain_config) : DATA_ZERO;

	// Damping factor lookup against the selected bandwidth
	// Factors are carried in tenths so 1.2 and 2.5 stay whole numbers
	wire [2:0] damping_code = loop1_damping_config.loop1_damping_code;
	wire [7:0] factor_code_4 = (i_loop1_bandwidth == BW_18_HZ) ? FACTOR_5 : FACTOR_10; // R2
	wire [7:0] factor_code_5 = (i_loop1_bandwidth == BW_18_HZ) ? FACTOR_5 :
		(i_loop1_bandwidth == BW_35_HZ) ? FACTOR_10 : FACTOR_20; // R2
	// Codes 0, 6 and 7 have no defined factor; they fall back to the reset factor
	wire [7:0] next_factor = (damping_code == DAMP_CODE_1) ? FACTOR_1P2 :
		(damping_code == DAMP_CODE_2) ? FACTOR_2P5 :
		(damping_code == DAMP_CODE_3) ? FACTOR_5 :
		(damping_code == DAMP_CODE_4) ? factor_code_4 :
		(damping_code == DAMP_CODE_5) ? factor_code_5 : FACTOR_5; // R1

	// First loop low frequency analog gain, gated by its own auto select
	// The gain value is always shown; the valid flag says when the loop may apply it
	wire next_lowfreq_valid = i_loop1_auto_gain_select &&
		(i_loop1_lock_mode == LOCK_ANALOG_LOW); // R3 R4
	wire [2:0] next_lowfreq_gain = loop1_damping_config.loop1_lowfreq_analog_gain; // R3

	// Second loop gain selection by lock mode
	// Analog low lock borrows the first loop field, the only 8 kHz gain field in this block
	wire       auto_select = loop2_detector_gain_config.loop2_auto_gain_select;
	wire [2:0] auto_gain =
		(i_loop2_lock_mode == LOCK_ANALOG_HIGH) ? loop2_detector_gain_config.loop2_highfreq_analog_gain :
		(i_loop2_lock_mode == LOCK_ANALOG_LOW) ? loop1_damping_config.loop1_lowfreq_analog_gain :
		loop2_detector_gain_config.loop2_digital_gain; // R6 R7
	// Digital gain stays on the output when auto select is off, so the loop sees a sane value
	wire [2:0] next_loop2_gain = auto_select ? auto_gain :
		loop2_detector_gain_config.loop2_digital_gain; // R8 R9

	// Registered outputs
	// Every output leaves a flop so the loops see no decode glitches
	// Read data changes only on a read strobe and holds for a slow front end
	always_ff @(posedge i_clock or negedge reset_sync_n) begin
		if (!reset_sync_n) begin
			o_read_data                <= DATA_ZERO;
			o_loop1_damping_factor     <= FACTOR_5;
			o_loop1_lowfreq_gain       <= GAIN_ZERO;
			o_loop1_lowfreq_gain_valid <= 1'b0;
			o_loop2_detector_enable    <= 1'b0;
			o_loop2_detector_gain      <= GAIN_ZERO;
		end else begin
			if (i_request.read_strobe) begin
				o_read_data <= next_read_data;
			end
			o_loop1_damping_factor     <= next_factor; // R1
			o_loop1_lowfreq_gain       <= next_lowfreq_gain; // R3
			o_loop1_lowfreq_gain_valid <= next_lowfreq_valid; // R4
			o_loop2_detector_enable    <= auto_select; // R5
			o_loop2_detector_gain      <= next_loop2_gain; // R9
		end
	end

	// Checks sleep while the internal reset copy is low
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!reset_sync_n);

	// Fixed factors for the low codes
	a_damp_fixed_codes: assert property ( // R1
		(damping_code == DAMP_CODE_2) |=> (o_loop1_damping_factor == FACTOR_2P5))
		else $error("Code 2 did not give factor 2.5");
	a_damp_code_one: assert property ( // R1
		(damping_code == DAMP_CODE_1) |=> (o_loop1_damping_factor == FACTOR_1P2))
		else $error("Code 1 did not give factor 1.2");
	// Bandwidth dependent codes
	a_damp_code_five: assert property ( // R2
		(damping_code == DAMP_CODE_5 && i_loop1_bandwidth == BW_70_HZ) |=> (o_loop1_damping_factor == FACTOR_20))
		else $error("Code 5 at 70 Hz did not give factor 20");
	a_damp_code_four: assert property ( // R2
		(damping_code == DAMP_CODE_4 && i_loop1_bandwidth == BW_18_HZ) |=> (o_loop1_damping_factor == FACTOR_5))
		else $error("Code 4 at 18 Hz did not give factor 5");
	// Low frequency gain gating on the first loop
	a_lowfreq_gate_off: assert property ( // R4
		!i_loop1_auto_gain_select |=> !o_loop1_lowfreq_gain_valid)
		else $error("Low frequency gain applied with auto select off");
	a_lowfreq_field_value: assert property ( // R3
		write_damping ##1 1'b1 |=> (o_loop1_lowfreq_gain == $past(next_damping[6:4], 2)))
		else $error("Low frequency gain does not follow bits 6 to 4");
	// Second loop enable and fallback gain
	a_loop2_enable_off: assert property ( // R5
		(write_gain && !i_request.write_data[7]) ##1 !write_gain |=> !o_loop2_detector_enable)
		else $error("Phase detector 2 enabled after clearing bit 7");
	a_loop2_disabled_gain: assert property ( // R8
		!auto_select |=> (o_loop2_detector_gain == $past(loop2_detector_gain_config.loop2_digital_gain)))
		else $error("Disabled auto select did not apply the digital gain");
	a_loop2_high_gain: assert property ( // R7
		(auto_select && i_loop2_lock_mode == LOCK_ANALOG_HIGH)
		|=> (o_loop2_detector_gain == $past(loop2_detector_gain_config.loop2_highfreq_analog_gain)))
		else $error("High analog lock did not use bits 6 to 4");
	a_loop2_auto_mode: assert property ( // R6
		(auto_select && i_loop2_lock_mode == LOCK_DIGITAL)
		|=> (o_loop2_detector_gain == $past(loop2_detector_gain_config.loop2_digital_gain)))
		else $error("Digital lock did not use the digital gain");

	// Middle code and the remaining bandwidth corners
	a_damp_code_three: assert property ( // R1
		(damping_code == DAMP_CODE_3) |=> (o_loop1_damping_factor == FACTOR_5))
		else $error("Code 3 did not give factor 5");
	a_damp_four_upper: assert property ( // R2
		(damping_code == DAMP_CODE_4 && i_loop1_bandwidth != BW_18_HZ)
		|=> (o_loop1_damping_factor == FACTOR_10))
		else $error("Code 4 above 18 Hz did not give factor 10");
	a_damp_five_low: assert property ( // R2
		(damping_code == DAMP_CODE_5 && i_loop1_bandwidth == BW_18_HZ)
		|=> (o_loop1_damping_factor == FACTOR_5))
		else $error("Code 5 at 18 Hz did not give factor 5");
	a_damp_five_mid: assert property ( // R2
		(damping_code == DAMP_CODE_5 && i_loop1_bandwidth == BW_35_HZ)
		|=> (o_loop1_damping_factor == FACTOR_10))
		else $error("Code 5 at 35 Hz did not give factor 10");
	// First loop gain applies in its own mode
	a_lowfreq_gate_on: assert property ( // R4
		(i_loop1_auto_gain_select && i_loop1_lock_mode == LOCK_ANALOG_LOW) |=> o_loop1_lowfreq_gain_valid)
		else $error("Low frequency gain not applied in analog low lock");
	// Second loop: enable mirrors bit 7, low mode borrows the first loop field
	a_loop2_enable_on: assert property ( // R5
		auto_select |=> o_loop2_detector_enable)
		else $error("Phase detector 2 not enabled with bit 7 set");
	a_loop2_low_gain: assert property ( // R6
		(auto_select && i_loop2_lock_mode == LOCK_ANALOG_LOW)
		|=> (o_loop2_detector_gain == $past(loop1_damping_config.loop1_lowfreq_analog_gain)))
		else $error("Analog low lock did not use the low frequency field");
	a_loop2_high_ignored: assert property ( // R8
		(!auto_select && i_loop2_lock_mode == LOCK_ANALOG_HIGH)
		|=> (o_loop2_detector_gain == $past(loop2_detector_gain_config.loop2_digital_gain)))
		else $error("High analog field used with auto select off");
	// Unused bits never stored, whatever the write carried
	a_damp_store_mask: assert property ( // R10
		write_damping |=> (loop1_damping_config.unused_7 == 1'b0 && loop1_damping_config.unused_3 == 1'b0))
		else $error("Unused damping bit stored a one");
	a_gain_store_mask: assert property ( // R10
		write_gain |=> (loop2_detector_gain_config.unused_3 == 1'b0))
		else $error("Unused gain bit stored a one");
	// Unused bits read zero after any write
	a_unused_bits_zero: assert property ( // R10
		(i_request.read_strobe && (hit_damping || hit_gain)) |=> (o_read_data[3] == 1'b0))
		else $error("Unused bit 3 read as one");
	a_damp_bit7_zero: assert property ( // R10
		(i_request.read_strobe && hit_damping) |=> (o_read_data[7] == 1'b0))
		else $error("Unused damping bit 7 read as one");

endmodule // loop_gain_config
`default_nettype wire

// [shared/loop_gain_pkg.sv]
// Constants and field layouts for the loop filter gain configuration registers
package loop_gain_pkg;
	// Register offsets on the serial configuration port
	localparam logic [7:0] LOOP1_DAMPING_OFFSET = 8'h6B;
	localparam logic [7:0] LOOP2_GAIN_OFFSET    = 8'h6C;
	// Reset values
	localparam logic [7:0] LOOP1_DAMPING_RESET  = 8'h13;
	localparam logic [7:0] LOOP2_GAIN_RESET     = 8'hC2;
	// Writable bit masks; unused bits read as zero
	localparam logic [7:0] LOOP1_DAMPING_MASK   = 8'h77;
	localparam logic [7:0] LOOP2_GAIN_MASK      = 8'hF7;
	// Damping codes
	localparam logic [2:0] DAMP_CODE_1  = 3'h1;
	localparam logic [2:0] DAMP_CODE_2  = 3'h2;
	localparam logic [2:0] DAMP_CODE_3  = 3'h3;
	localparam logic [2:0] DAMP_CODE_4  = 3'h4;
	localparam logic [2:0] DAMP_CODE_5  = 3'h5;
	// Damping factors in tenths
	localparam logic [7:0] FACTOR_1P2   = 8'h0C;
	localparam logic [7:0] FACTOR_2P5   = 8'h19;
	localparam logic [7:0] FACTOR_5     = 8'h32;
	localparam logic [7:0] FACTOR_10    = 8'h64;
	localparam logic [7:0] FACTOR_20    = 8'hC8;
	localparam logic [7:0] DATA_ZERO    = 8'h00;
	localparam logic [2:0] GAIN_ZERO    = 3'h0;

	// Selected loop bandwidth
	typedef enum logic [1:0] {
		BW_18_HZ = 2'b00,
		BW_35_HZ = 2'b01,
		BW_70_HZ = 2'b10
	} bandwidth_type;

	// Locking mode of a loop
	typedef enum logic [1:0] {
		LOCK_DIGITAL     = 2'b00,
		LOCK_ANALOG_HIGH = 2'b01,
		LOCK_ANALOG_LOW  = 2'b10
	} lock_mode_type;

	// First loop damping register layout
	typedef struct packed {
		logic       unused_7;
		logic [2:0] loop1_lowfreq_analog_gain;
		logic       unused_3;
		logic [2:0] loop1_damping_code;
	} damping_reg_type;

	// Second loop detector gain register layout
	typedef struct packed {
		logic       loop2_auto_gain_select;
		logic [2:0] loop2_highfreq_analog_gain;
		logic       unused_3;
		logic [2:0] loop2_digital_gain;
	} gain_reg_type;

	// Register access request from the serial port front end
	typedef struct packed {
		logic       write_strobe;
		logic       read_strobe;
		logic [7:0] address;
		logic [7:0] write_data;
	} reg_request_type;
endpackage

// [tb/loop_gain_config_test.sv]
// Self-checking testbench for the loop gain configuration registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module loop_gain_config_test import loop_gain_pkg::*;;
	logic            clock;
	logic            reset_n;
	reg_request_type request;
	bandwidth_type   bw;
	lock_mode_type   mode1;
	logic            auto1;
	lock_mode_type   mode2;
	logic [7:0]      rdata;
	logic [7:0]      factor;
	logic [2:0]      lf_gain;
	logic            lf_valid;
	logic            l2_en;
	logic [2:0]      l2_gain;
	int              err_total;
	int              samples_checked;

	loop_gain_config i_loop_gain_config (.i_clock(clock), .i_reset_n(reset_n), .i_request(request),
		.i_loop1_bandwidth(bw), .i_loop1_lock_mode(mode1), .i_loop1_auto_gain_select(auto1),
		.i_loop2_lock_mode(mode2), .o_read_data(rdata), .o_loop1_damping_factor(factor),
		.o_loop1_lowfreq_gain(lf_gain), .o_loop1_lowfreq_gain_valid(lf_valid),
		.o_loop2_detector_enable(l2_en), .o_loop2_detector_gain(l2_gain));

	// 100 MHz clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Expected damping factor in tenths, unknown codes fall back to 5
	function automatic logic [7:0] exp_factor(input logic [2:0] c, input logic [1:0] b);
		case (c)
			DAMP_CODE_1: exp_factor = FACTOR_1P2;
			DAMP_CODE_2: exp_factor = FACTOR_2P5;
			DAMP_CODE_4: exp_factor = (b == 2'h0) ? FACTOR_5 : FACTOR_10;
			DAMP_CODE_5: exp_factor = (b == 2'h0) ? FACTOR_5 : ((b == 2'h1) ? FACTOR_10 : FACTOR_20);
			default: exp_factor = FACTOR_5;
		endcase
	endfunction

	// Derived outputs lag a write by two cycles, so give them three
	task automatic settle();
		repeat (3) @(posedge clock);
		@(negedge clock);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		request <= {1'b1, 1'b0, a, d};
		@(posedge clock);
		request <= '0;
		settle();
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		request <= {1'b0, 1'b1, a, 8'h00};
		@(posedge clock);
		request <= '0;
		@(negedge clock);
		`CHK(rdata, e)
	endtask

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#200us;
		err_total++;
		end_sim();
	end

	// Main sequence
	initial begin
		err_total = 0;
		samples_checked = 0;
		reset_n = 1'b0;
		request = '0;
		bw = BW_18_HZ;
		mode1 = LOCK_DIGITAL;
		auto1 = 1'b0;
		mode2 = LOCK_DIGITAL;
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		repeat (4) @(posedge clock);
		rd(LOOP1_DAMPING_OFFSET, 8'h13);
		rd(LOOP2_GAIN_OFFSET, 8'hC2);
		wr(LOOP1_DAMPING_OFFSET, 8'hFF);
		`CHK(factor, FACTOR_5)
		`CHK(lf_gain, 3'h7)
		rd(LOOP1_DAMPING_OFFSET, 8'h77);
		wr(LOOP2_GAIN_OFFSET, 8'hFF);
		rd(LOOP2_GAIN_OFFSET, 8'hF7);
		wr(8'h10, 8'hAA);
		rd(8'h10, 8'h00);
		rd(LOOP1_DAMPING_OFFSET, 8'h77);
		// Every defined damping code at every bandwidth
		for (int c = 1; c <= 5; c++) begin
			for (int b = 0; b <= 2; b++) begin
				@(posedge clock);
				bw <= bandwidth_type'(b[1:0]);
				wr(LOOP1_DAMPING_OFFSET, {5'h00, c[2:0]});
				`CHK(factor, exp_factor(c[2:0], b[1:0]))
			end
		end
		// Low frequency field applies only with auto select in analog low mode
		wr(LOOP1_DAMPING_OFFSET, 8'h55);
		`CHK(lf_gain, 3'h5)
		for (int a = 0; a <= 1; a++) begin
			for (int m = 0; m <= 2; m++) begin
				@(posedge clock);
				auto1 <= a[0];
				mode1 <= lock_mode_type'(m[1:0]);
				settle();
				`CHK(lf_valid, (a == 1 && m == 2))
			end
		end
		// Second loop gain selection by enable bit and lock mode
		for (int e = 0; e <= 1; e++) begin
			wr(LOOP2_GAIN_OFFSET, {e[0], 3'h6, 1'b0, 3'h2});
			for (int m = 0; m <= 2; m++) begin
				@(posedge clock);
				mode2 <= lock_mode_type'(m[1:0]);
				settle();
				`CHK(l2_en, e[0])
				`CHK(l2_gain, (e == 0 || m == 0) ? 3'h2 : ((m == 1) ? 3'h6 : 3'h5))
			end
		end
		// Reset in mid-run: outputs drop at once, registers reload their defaults
		@(posedge clock);
		reset_n <= 1'b0;
		@(negedge clock);
		`CHK(factor, FACTOR_5)
		`CHK({l2_en, l2_gain, lf_valid, lf_gain}, 8'h00)
		`CHK(rdata, 8'h00)
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		repeat (4) @(posedge clock);
		rd(LOOP1_DAMPING_OFFSET, 8'h13);
		rd(LOOP2_GAIN_OFFSET, 8'hC2);
		settle();
		`CHK(factor, FACTOR_5)
		`CHK(lf_gain, 3'h1)
		`CHK(l2_en, 1'b1)
		`CHK(l2_gain, 3'h1)
		end_sim();
	end
endmodule // loop_gain_config_test
`default_nettype wire
